// >>> smc_defines.svh
// Purpose: Constants of the six-channel converter serial and mode control.
// Assumes: The master clock is the 200 MHz reference clock.
// Notes: Bit positions sit in 8-bit control registers, apart from the serial word fields at bits 15, 11 and 8.
`ifndef SMC_DEFINES_SVH
`define SMC_DEFINES_SVH
`define SMC_NUM_REGS 8
`define SMC_NUM_CHAN 6
`define SMC_WORD_BITS 16
`define SMC_REG_FIRST 3'h0
`define SMC_REG_SECOND 3'h1
`define SMC_REG_POWER 3'h2
`define SMC_REG_CHAN_BASE 3
`define SMC_DP_BIT 0
`define SMC_MM_BIT 1
`define SMC_SWRST_BIT 7
`define SMC_DECIM_LO 0
`define SMC_SCLK_LO 2
`define SMC_MCD_LO 4
`define SMC_GPU_BIT 0
`define SMC_REFPU_BIT 5
`define SMC_CHPWR_BIT 3
`define SMC_W_FLAG 15
`define SMC_W_ADDR_LO 11
`define SMC_W_REG_LO 8
`define SMC_RESET_DIVIDED_MASTER_CLOCK 4
`define SMC_FIRST_FS_MCLK 2070
`define SMC_REF_PER_MCLK 1
`define SMC_FIRST_FS_CYC (`SMC_FIRST_FS_MCLK * `SMC_REF_PER_MCLK)
`endif

// >>> smc_host.sv
// Purpose: Host serial port model feeding words to the device.
// Assumes: Bit period of at least four reference clocks.
// Notes: Moves its pins at the falling edge after each tick.
`timescale 1ns/100ps
module smc_host (
  input wire logic clk,
  input wire logic sclk,
  output logic fs,
  output logic sd
);
  initial begin
    fs = 1'b0;
    sd = 1'b1;
  end
  // One sync period, then sixteen bits MSB first, one word per call.
  task automatic send(input logic [15:0] w);
    int i;
    @(posedge clk iff sclk);
    @(negedge clk);
    fs = 1'b1;
    for (i = 15; i >= 0; i--) begin
      @(posedge clk iff sclk);
      @(negedge clk);
      fs = 1'b0;
      sd = w[i];
    end
    @(posedge clk iff sclk);
    @(negedge clk);
    sd = ~sd; // Released line shows the inverse so a stale bit never matches.
  endtask : send
endmodule : smc_host

// >>> smc_pkg.sv
// Purpose: Types of the six-channel converter serial and mode control.
// Assumes: Nothing beyond the constants header.
// Notes: Codes are one-hot.
package smc_pkg;
  typedef enum logic [2:0] {
    SMC_MODE_PGM = 3'h1,
    SMC_MODE_DATA = 3'h2,
    SMC_MODE_MIXED = 3'h4
  } smc_mode_t;
  typedef enum logic [2:0] {
    SMC_TX_IDLE = 3'h1,
    SMC_TX_SYNC = 3'h2,
    SMC_TX_SHIFT = 3'h4
  } smc_tx_t;
endpackage : smc_pkg

// >>> smc_sva.sv
// Purpose: Port checks of smc_top.
// Assumes: Bound to every smc_top instance.
// Notes: Sees the top ports only.
`include "smc_defines.svh"
`timescale 1ns/100ps
module smc_sva import smc_pkg::*; #(
  parameter int FIFO_DEPTH = 4,
  parameter int SAMPLE_W = 16
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic port_enable_pin,
  input wire logic serial_data_in,
  input wire logic input_frame_sync,
  input wire logic serial_clk,
  input wire logic output_frame_sync,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en_n,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic [`SMC_NUM_CHAN-1:0] channel_power_on,
  input wire logic reference_power_on,
  input wire smc_mode_t operating_mode,
  input wire logic reset_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Pins move only on serial ticks, so a host clocked by the tick sees settled bits.
  a_fs_on_tick: assert property (!reset_busy && $changed(output_frame_sync) |-> serial_clk)
    else $error("frame sync moved off a tick");
  a_sdo_on_tick: assert property (!reset_busy && $changed(serial_data_out) |-> serial_clk)
    else $error("data moved off a tick");
  a_en_on_tick: assert property (!reset_busy && $changed(serial_data_out_en_n) |-> serial_clk)
    else $error("enable moved off a tick");
  a_sync_drives: assert property (output_frame_sync |-> !serial_data_out_en_n)
    else $error("sync in a released slot");
  // A soft reset lasts four divided clocks, one cycle each with cleared dividers.
  a_busy_len: assert property ($rose(reset_busy) |-> reset_busy [*4] ##1 !reset_busy)
    else $error("reset length wrong");
  a_rst_clear: assert property ($rose(reset_busy) |=>
    (channel_power_on == '0 && operating_mode == SMC_MODE_PGM))
    else $error("reset left settings");
  a_data_locked: assert property ((operating_mode == SMC_MODE_DATA && !reset_busy) |=>
    (operating_mode == SMC_MODE_DATA && $stable(channel_power_on)))
    else $error("data mode setting changed");
  a_ref_follows: assert property ((channel_power_on != '0) |-> reference_power_on)
    else $error("reference off with channel on");
endmodule : smc_sva

bind smc_top smc_sva #(.FIFO_DEPTH(FIFO_DEPTH), .SAMPLE_W(SAMPLE_W)) u_sva (
  .ref_clk(ref_clk), .arst_n(arst_n), .port_enable_pin(port_enable_pin),
  .serial_data_in(serial_data_in), .input_frame_sync(input_frame_sync),
  .serial_clk(serial_clk), .output_frame_sync(output_frame_sync),
  .serial_data_out(serial_data_out), .serial_data_out_en_n(serial_data_out_en_n),
  .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
  .channel_power_on(channel_power_on), .reference_power_on(reference_power_on),
  .operating_mode(operating_mode), .reset_busy(reset_busy));

// >>> smc_top.sv
// Purpose: Serial timing, mode control and cascade addressing of a six-channel front end.
// Assumes: Master clock equals ref_clk; samples arrive on a valid/ready stream.
// Notes: The serial clock pin is a one-cycle pulse that opens each bit period.
// Contract
// - Serial clock divides divided master clock by 8/4/2/1.
// - Sample period is 2048/1024/512/256 divided master clocks.
// - Outside program mode, unpowered slot with no forwarded word sends nothing, output released.
// - After reset: program mode, one sync per sample.
// - One control word accepted per frame sync.
// - Words before data mode carry no samples.
// - Hardware reset clears all control registers.
// - Software reset bit acts like reset pin.
// - Either reset lasts four divided clock cycles.
// - First frame sync about 2070 clocks after reset.
// - Global bit powers all; reference keeps own bit.
// - Channel power follows its own bit.
// - Registers change only in program or mixed mode.
// - Every serial word is sixteen bits.
// - Program mode treats every word as control.
// - Address zero accepts; otherwise decrement and forward.
// - Frame syncs start only with port enable high.
// - Default rate until second register is written.
// - Data bit set, mixed clear: data mode.
// - Data mode ignores all received words.
// - Mixed and data bits set: mixed mode.
// - Mixed mode: flagged words control, samples MSB zero.
// - Divided master clock is clock over 1..5.
`include "smc_defines.svh"
`timescale 1ns/100ps
module smc_fifo #(
  parameter int W = 16,
  parameter int D = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } smc_fifo_st_t;
  smc_fifo_st_t q;
  smc_fifo_st_t d;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = q.cnt != (AW+1)'(D);
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers wrap at the depth, so depths need not be powers of two.
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : smc_fifo

module smc_top import smc_pkg::*; #(
  parameter int FIFO_DEPTH = 4,
  parameter int SAMPLE_W = `SMC_WORD_BITS
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic port_enable_pin,
  input wire logic serial_data_in,
  input wire logic input_frame_sync,
  output logic serial_clk,
  output logic output_frame_sync,
  output logic serial_data_out,
  output logic serial_data_out_en_n,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [SAMPLE_W-1:0] sample_data,
  output logic [`SMC_NUM_CHAN-1:0] channel_power_on,
  output logic reference_power_on,
  output smc_mode_t operating_mode,
  output logic reset_busy
);
  typedef struct packed {
    logic [`SMC_NUM_REGS-1:0][7:0] regs;
    logic crb_written;
    logic [2:0] dm_cnt;
    logic [2:0] sc_cnt;
    logic [10:0] samp_cnt;
    logic first_wait;
    logic [11:0] first_cnt;
    logic rst_busy;
    logic [2:0] rst_cnt;
    logic sdi_s1;
    logic sdi_s2;
    logic fsi_s1;
    logic fsi_s2;
    logic pen_s1;
    logic pen_s2;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    smc_tx_t tx_st;
    logic [15:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [2:0] slot;
    logic frame_pend;
    logic [15:0] pass_word;
    logic pass_valid;
    logic sclk_q;
    logic fso_q;
    logic sdo_q;
    logic sdo_en_n_q;
  } smc_st_t;

  smc_st_t q;
  smc_st_t d;
  logic rst_s1_q;
  logic rst_s2_q;
  logic fifo_valid;
  logic fifo_pop;
  logic [SAMPLE_W-1:0] fifo_data;
  logic [`SMC_NUM_CHAN-1:0] chan_pwr;
  logic global_pu;
  smc_mode_t mode;

  // Divided master clock period minus one; unused codes fall back to one.
  function automatic logic [2:0] mcd_m1(input logic [2:0] sel);
    if (sel <= 3'h4) begin
      mcd_m1 = sel;
    end else begin
      mcd_m1 = 3'h0;
    end
  endfunction : mcd_m1

  // Serial clock period in divided clocks, minus one.
  function automatic logic [2:0] sclk_m1(input logic [1:0] sel);
    case (sel)
      2'h0: sclk_m1 = 3'h7;
      2'h1: sclk_m1 = 3'h3;
      2'h2: sclk_m1 = 3'h1;
      default: sclk_m1 = 3'h0;
    endcase
  endfunction : sclk_m1

  // Sample period in divided clocks, minus one.
  function automatic logic [10:0] samp_m1(input logic [1:0] sel);
    case (sel)
      2'h0: samp_m1 = 11'h7ff;
      2'h1: samp_m1 = 11'h3ff;
      2'h2: samp_m1 = 11'h1ff;
      default: samp_m1 = 11'h0ff;
    endcase
  endfunction : samp_m1

  // The released reset is the synchronised copy used everywhere else.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  // Sample buffer; draining only in output slots gives real back-pressure.
  smc_fifo #(.W(SAMPLE_W), .D(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
    .clk(ref_clk),
    .rst_n(rst_s2_q),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Mode decode of the first control register.
  always_comb begin
    if (q.regs[0][`SMC_DP_BIT] && q.regs[0][`SMC_MM_BIT]) begin
      mode = SMC_MODE_MIXED;
    end else if (q.regs[0][`SMC_DP_BIT]) begin
      mode = SMC_MODE_DATA;
    end else begin
      mode = SMC_MODE_PGM;
    end
  end

  // Power gating; the reference also wakes for any live channel.
  assign global_pu = q.regs[`SMC_REG_POWER][`SMC_GPU_BIT];
  for (genvar i = 0; i < `SMC_NUM_CHAN; i++) begin : g_pwr
    assign chan_pwr[i] = global_pu ||
      q.regs[`SMC_REG_CHAN_BASE + i / 2][`SMC_CHPWR_BIT + 4 * (i % 2)];
  end
  assign reference_power_on = global_pu || q.regs[`SMC_REG_POWER][`SMC_REFPU_BIT] ||
    (|chan_pwr);
  assign channel_power_on = chan_pwr;
  assign operating_mode = mode;
  assign reset_busy = q.rst_busy;
  assign serial_clk = q.sclk_q;
  assign output_frame_sync = q.fso_q;
  assign serial_data_out = q.sdo_q;
  assign serial_data_out_en_n = q.sdo_en_n_q;

  // Next state of all timing, framing and control logic.
  always_comb begin
    logic dm_tick;
    logic bit_tick;
    logic samp_event;
    logic load_slot;
    logic [2:0] load_idx;
    logic powered;
    logic drive;
    logic word_done;
    logic is_ctrl;
    logic swrst;
    logic [15:0] word;
    logic [15:0] out_w;
    logic [1:0] rate_sel;
    dm_tick = 1'b0;
    bit_tick = 1'b0;
    samp_event = 1'b0;
    load_slot = 1'b0;
    load_idx = 3'h0;
    powered = 1'b0;
    drive = 1'b0;
    word_done = 1'b0;
    is_ctrl = 1'b0;
    swrst = 1'b0;
    word = 16'h0000;
    out_w = 16'h0000;
    rate_sel = 2'h0;
    fifo_pop = 1'b0;
    d = q;

    // Pin inputs pass two flip-flops before use.
    d.sdi_s1 = serial_data_in;
    d.sdi_s2 = q.sdi_s1;
    d.fsi_s1 = input_frame_sync;
    d.fsi_s2 = q.fsi_s1;
    d.pen_s1 = port_enable_pin;
    d.pen_s2 = q.pen_s1;

    // Free-running divider chain from master to serial clock.
    dm_tick = q.dm_cnt >= mcd_m1(q.regs[1][`SMC_MCD_LO +: 3]);
    d.dm_cnt = dm_tick ? 3'h0 : q.dm_cnt + 3'h1;
    bit_tick = dm_tick && (q.sc_cnt >= sclk_m1(q.regs[1][`SMC_SCLK_LO +: 2]));
    if (dm_tick) begin
      d.sc_cnt = bit_tick ? 3'h0 : q.sc_cnt + 3'h1;
    end
    d.sclk_q = bit_tick;

    // Sample timing; the default rate holds until the rate register is written.
    rate_sel = q.crb_written ? q.regs[1][`SMC_DECIM_LO +: 2] : 2'h0;
    if (q.first_wait) begin
      d.samp_cnt = 11'h000;
      d.first_cnt = q.first_cnt + 12'h001;
      if (q.first_cnt == 12'(`SMC_FIRST_FS_CYC - 1)) begin
        d.first_wait = 1'b0;
        samp_event = 1'b1;
      end
    end else if (dm_tick) begin
      if (q.samp_cnt >= samp_m1(rate_sel)) begin
        d.samp_cnt = 11'h000;
        samp_event = 1'b1;
      end else begin
        d.samp_cnt = q.samp_cnt + 11'h001;
      end
    end

    // Output slots: sync bit, then sixteen data bits per slot.
    if (bit_tick) begin
      case (q.tx_st)
        SMC_TX_IDLE: begin
          if (q.frame_pend && q.pen_s2) begin
            d.frame_pend = 1'b0;
            load_slot = 1'b1;
          end
        end
        SMC_TX_SYNC: begin
          d.tx_st = SMC_TX_SHIFT;
          d.fso_q = 1'b0;
          d.sdo_q = q.tx_sh[15];
          d.tx_sh = {q.tx_sh[14:0], 1'b0};
          d.tx_cnt = 4'hf;
        end
        SMC_TX_SHIFT: begin
          if (q.tx_cnt != 4'h0) begin
            d.sdo_q = q.tx_sh[15];
            d.tx_sh = {q.tx_sh[14:0], 1'b0};
            d.tx_cnt = q.tx_cnt - 4'h1;
          end else if (mode == SMC_MODE_PGM || q.slot == 3'(`SMC_NUM_CHAN - 1)) begin
            d.tx_st = SMC_TX_IDLE;
            d.sdo_q = 1'b0;
            d.sdo_en_n_q = 1'b1;
          end else begin
            load_slot = 1'b1;
            load_idx = q.slot + 3'h1;
          end
        end
        default: begin
          d.tx_st = SMC_TX_IDLE;
        end
      endcase
    end

    // Pending sync is set after the slot logic, so an event on the consuming tick is kept.
    if (samp_event && q.pen_s2 && !q.rst_busy) begin
      d.frame_pend = 1'b1;
    end

    // Word choice for a slot: forwarded word first, then a sample, else filler.
    if (load_slot) begin
      powered = (mode == SMC_MODE_PGM) ? 1'b1 : chan_pwr[load_idx];
      drive = powered || q.pass_valid;
      if (q.pass_valid) begin
        out_w = q.pass_word;
        d.pass_valid = 1'b0;
      end else if (mode != SMC_MODE_PGM && powered && fifo_valid) begin
        fifo_pop = 1'b1;
        out_w = 16'(fifo_data);
        if (mode == SMC_MODE_MIXED) begin
          out_w[`SMC_W_FLAG] = 1'b0;
        end
      end else begin
        out_w = 16'h0000;
      end
      d.tx_st = SMC_TX_SYNC;
      d.slot = load_idx;
      d.tx_sh = out_w;
      d.fso_q = drive;
      d.sdo_q = 1'b0;
      d.sdo_en_n_q = !drive;
    end

    // Receive shifter, armed by the input frame sync.
    if (bit_tick) begin
      if (q.rx_cnt == 5'h00) begin
        if (q.fsi_s2) begin
          d.rx_cnt = 5'h10;
        end
      end else begin
        d.rx_sh = {q.rx_sh[14:0], q.sdi_s2};
        d.rx_cnt = q.rx_cnt - 5'h01;
        if (q.rx_cnt == 5'h01) begin
          word_done = 1'b1;
          word = {q.rx_sh[14:0], q.sdi_s2};
        end
      end
    end

    // Control word handling by mode and cascade address.
    if (word_done && !q.rst_busy) begin
      case (mode)
        SMC_MODE_PGM: is_ctrl = 1'b1;
        SMC_MODE_MIXED: is_ctrl = word[`SMC_W_FLAG];
        default: is_ctrl = 1'b0;
      endcase
      if (is_ctrl) begin
        if (word[`SMC_W_ADDR_LO +: 3] == 3'h0) begin
          d.regs[word[`SMC_W_REG_LO +: 3]] = word[7:0];
          if (word[`SMC_W_REG_LO +: 3] == `SMC_REG_SECOND) begin
            d.crb_written = 1'b1;
          end
          if (word[`SMC_W_REG_LO +: 3] == `SMC_REG_FIRST && word[`SMC_SWRST_BIT]) begin
            swrst = 1'b1;
          end
        end else begin
          d.pass_word = word;
          d.pass_word[`SMC_W_ADDR_LO +: 3] = word[`SMC_W_ADDR_LO +: 3] - 3'h1;
          d.pass_valid = 1'b1;
        end
      end
    end

    // Reset sequence: registers held at zero for four divided clocks.
    if (swrst) begin
      d.rst_busy = 1'b1;
      d.rst_cnt = 3'h0;
    end else if (q.rst_busy && dm_tick) begin
      d.rst_cnt = q.rst_cnt + 3'h1;
      if (q.rst_cnt == 3'(`SMC_RESET_DIVIDED_MASTER_CLOCK - 1)) begin
        d.rst_busy = 1'b0;
      end
    end
    if (swrst || q.rst_busy) begin
      d.regs = '0;
      d.crb_written = 1'b0;
      d.pass_valid = 1'b0;
      d.frame_pend = 1'b0;
      d.tx_st = SMC_TX_IDLE;
      d.rx_cnt = 5'h00;
      d.fso_q = 1'b0;
      d.sdo_q = 1'b0;
      d.sdo_en_n_q = 1'b1;
      d.samp_cnt = 11'h000;
      fifo_pop = 1'b0;
    end
  end

  // State register; reset values put the device in a busy program mode.
  always_ff @(posedge ref_clk or negedge rst_s2_q) begin
    if (!rst_s2_q) begin
      q <= '0;
      q.tx_st <= SMC_TX_IDLE;
      q.rst_busy <= 1'b1;
      q.first_wait <= 1'b1;
      q.sdo_en_n_q <= 1'b1;
    end else begin
      q <= d;
    end
  end
endmodule : smc_top

// >>> smc_top_tb_top.sv
// Purpose: Self-checking bench of smc_top.
// Assumes: Host model on the serial input, bench on the sample stream.
// Notes: Output words are matched in order against a queue.
`include "smc_defines.svh"
`timescale 1ns/100ps
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_errors++; \
  $display("unexpected %s exp %h got %h", nm, e, s); end end
module smc_top_tb_top import smc_pkg::*;;
  logic ref_clk, arst_n, port_enable_pin, serial_data_in, input_frame_sync;
  logic serial_clk, output_frame_sync, serial_data_out, serial_data_out_en_n;
  logic sample_valid, sample_ready, reference_power_on, reset_busy;
  logic [15:0] sample_data, w, exp_w;
  logic [5:0] channel_power_on;
  smc_mode_t operating_mode;
  logic [15:0] exp_q [$];
  int n_errors = 0, n_compared = 0, i, j, g, k, cnt;
  logic [7:0] rv [6] = '{8'h04, 8'h1a, 8'h4f, 8'h25, 8'h70, 8'h03};
  int sp [6] = '{4, 4, 5, 12, 8, 8};
  int fp [6] = '{2048, 1024, 1280, 3072, 2048, 256};
  smc_top dut (.ref_clk(ref_clk), .arst_n(arst_n), .port_enable_pin(port_enable_pin),
    .serial_data_in(serial_data_in), .input_frame_sync(input_frame_sync),
    .serial_clk(serial_clk), .output_frame_sync(output_frame_sync),
    .serial_data_out(serial_data_out), .serial_data_out_en_n(serial_data_out_en_n),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .sample_data(sample_data),
    .channel_power_on(channel_power_on), .reference_power_on(reference_power_on),
    .operating_mode(operating_mode), .reset_busy(reset_busy));
  smc_host host (.clk(ref_clk), .sclk(serial_clk), .fs(input_frame_sync),
    .sd(serial_data_in));
  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;
  task automatic conclude();
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Standalone device accepts address zero; other addresses are forwarded.
  task automatic wr(input logic [2:0] a, input logic [2:0] r, input logic [7:0] d);
    host.send({2'b00, a, r, d});
  endtask : wr
  task automatic hwrst();
    @(negedge ref_clk);
    arst_n = 1'b0;
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    repeat (8) @(negedge ref_clk);
  endtask : hwrst
  // Cycles from one frame sync rise to the next, and between serial ticks.
  task automatic gap();
    // The loop below leaves one falling edge after the rise, so start one short.
    g = -1;
    @(negedge output_frame_sync);
    while (!output_frame_sync && g < 9000) begin @(negedge ref_clk); g++; end
    @(posedge serial_clk);
    @(negedge ref_clk);
    k = 0;
    do begin @(negedge ref_clk); k++; end while (!serial_clk && k < 99);
  endtask : gap
  task automatic drain();
    cnt = 0;
    while (exp_q.size() != 0 && cnt < 12000) begin @(negedge ref_clk); cnt++; end
    `CHK("drained", 1'b1, exp_q.size() == 0)
  endtask : drain
  // Capture every framed output word and match nonzero ones in order.
  always begin
    @(posedge ref_clk iff (serial_clk && output_frame_sync));
    for (i = 15; i >= 0; i--) begin
      @(posedge ref_clk iff serial_clk);
      #1 w[i] = serial_data_out;
    end
    // Take the note once; a nonzero word with no note left is a stray word.
    if (w != 16'h0) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 16'h0000;
      `CHK("word", exp_w, w)
    end
  end
  // Watchdog at about one and a half times the planned run, so a hang still ends the test.
  initial begin
    #450us;
    n_errors++;
    conclude();
  end
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    port_enable_pin = 1'b1;
    sample_valid = 1'b0;
    sample_data = 16'h0;
    void'($urandom(32'h69a1));
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    @(negedge ref_clk);
    `CHK("mode", SMC_MODE_PGM, operating_mode)
    `CHK("power", 7'h0, {reference_power_on, channel_power_on})
    cnt = 1;
    while (!output_frame_sync && cnt < 3000) begin @(negedge ref_clk); cnt++; end
    `CHK("first_sync", 1'b1, cnt > 2060 && cnt < 2090)
    gap();
    `CHK("default_rate", 2048, g + k)
    wr(3'h0, 3'h2, 8'h01);
    `CHK("global", 7'h7f, {reference_power_on, channel_power_on})
    wr(3'h0, 3'h2, 8'h20);
    `CHK("ref_only", 7'h40, {reference_power_on, channel_power_on})
    wr(3'h0, 3'h3, 8'h88);
    wr(3'h0, 3'h5, 8'h80);
    `CHK("chan", 6'h23, channel_power_on)
    exp_q.push_back(16'h1488);
    wr(3'h3, 3'h4, 8'h88);
    `CHK("not_mine", 6'h23, channel_power_on)
    drain();
    wr(3'h0, 3'h0, 8'h80);
    `CHK("soft_rst", 6'h00, channel_power_on)
    for (j = 0; j < 6; j++) begin
      wr(3'h0, 3'h1, rv[j]);
      gap();
      gap();
      `CHK("sclk", sp[j], k)
      `CHK("sample", fp[j], g + k)
    end
    hwrst();
    gap();
    `CHK("hw_rst", 8, k)
    `CHK("hw_rst_rate", 2048, g + k)
    // Port enable held low through a reset must keep the frame sync quiet.
    port_enable_pin = 1'b0;
    hwrst();
    cnt = 0;
    repeat (3000) begin @(negedge ref_clk); cnt += output_frame_sync; end
    `CHK("no_sync", 0, cnt)
    port_enable_pin = 1'b1;
    wr(3'h0, 3'h3, 8'h08);
    wr(3'h0, 3'h4, 8'h08);
    wr(3'h0, 3'h0, 8'h01);
    `CHK("data", SMC_MODE_DATA, operating_mode)
    `CHK("chan13", 6'h05, channel_power_on)
    // Fill the FIFO until it refuses; acceptance is decided by ready before the edge.
    sample_valid = 1'b1;
    k = 0;
    while (sample_ready && k < 9) begin
      sample_data = 16'($urandom) | 16'h1;
      exp_q.push_back(sample_data);
      @(negedge ref_clk);
      k++;
    end
    sample_valid = 1'b0;
    `CHK("fill", 1'b1, k >= 4)
    drain();
    wr(3'h0, 3'h2, 8'h01);
    `CHK("ignored", 6'h05, channel_power_on)
    hwrst();
    wr(3'h0, 3'h0, 8'h03);
    `CHK("mixed", SMC_MODE_MIXED, operating_mode)
    host.send(16'h8308);
    host.send(16'h0388);
    `CHK("flagged", 6'h01, channel_power_on)
    sample_data = 16'hf00d;
    sample_valid = 1'b1;
    exp_q.push_back(16'h700d);
    @(negedge ref_clk);
    sample_valid = 1'b0;
    drain();
    conclude();
  end
endmodule : smc_top_tb_top
